// ==== core/idpg_page.sv ====
// parameter page generator: streams the 256-word identify page
`timescale 1ns/10ps
`include "idpg_defs.svh"
// How it works
// - serial right-aligned, leading positions hold spaces
// - ecc byte count word is fixed 0004h
// - model left-aligned, trailing positions hold spaces
// - multiple limit: 80h or 00h, max count
// - card sector count is first out-of-range lba
// - capability bit 9 always one
// - capability bit 8 mirrors dma command acceptance
// - capability bits 13 and 11 read zero
// - pio mode byte only 00h to 02h
// - validity bit 0 always one
// - validity bit 1 marks words 64-70
// - current capacity is cylinders times heads times sectors
// - multiple setting: bit 8 one, count low
// - selected dma mode: at most one bit
// - supported dma modes: several bits allowed
// - advanced pio bits 0 and 1 only
// - word 65 minimum dma cycle in ns
// - word 66 never below word 65
// - unsupported cycle field returns zero
// - word 67 never below word 68
// - word 68 fastest pio cycle with ready
// - started by command ech, sector-read protocol
module idpg_page #(
   parameter logic [15:0] CONFIG_WORD = 16'h848a,
   parameter logic [7:0] MULT_UPPER = `IDPG_MULT_REC,
   parameter int SERIAL_LEN = 8,
   parameter int MODEL_LEN = 12,
   parameter logic [8*`IDPG_SERIAL_CHARS-1:0] SERIAL_STR = {20{8'h30}},
   parameter logic [8*`IDPG_FW_CHARS-1:0] FW_STR = {8{8'h31}},
   parameter logic [8*`IDPG_MODEL_CHARS-1:0] MODEL_STR = {40{8'h41}}
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic word_ready,
   output logic word_valid,
   output logic [15:0] word_data,
   output logic [7:0] word_addr,
   output logic page_last,
   output logic page_busy,
   input wire idpg_pkg::idpg_geom_t def_geom,
   input wire idpg_pkg::idpg_geom_t cur_geom,
   input wire logic [31:0] card_sectors,
   input wire logic [31:0] lba_sectors,
   input wire logic [7:0] mult_max,
   input wire logic [7:0] mult_current,
   input wire idpg_pkg::idpg_modes_t modes,
   input wire logic sec_max_level
);
   idpg_pkg::idpg_state_t state;
   logic [7:0] addr;
   logic [15:0] next_word;
   logic [47:0] cap_full;
   logic [31:0] cap;
   logic adv_valid;
   logic [15:0] caps_word;
   logic [7:0] pio_byte;
   logic [7:0] dma_sel_byte;
   logic [15:0] dma_min_f;
   logic [15:0] dma_rec_f;
   logic [15:0] pio_min_f;
   logic [15:0] pio_rdy_f;
   logic [7:0] serial_ch [0:`IDPG_SERIAL_CHARS-1];
   logic [7:0] model_ch [0:`IDPG_MODEL_CHARS-1];
   logic accept;
   logic load;

   // ------------------------------------------------------------
   // string character maps
   // ------------------------------------------------------------
   // serial: characters sit at the end, spaces fill the front
   genvar gi;
   generate
      for (gi = 0; gi < `IDPG_SERIAL_CHARS; gi++) begin : g_ser
         localparam int OFF = `IDPG_SERIAL_CHARS - SERIAL_LEN;
         if (gi < OFF) begin : g_pad
            assign serial_ch[gi] = `IDPG_SPACE;
         end else begin : g_chr
            assign serial_ch[gi] = SERIAL_STR[8*(SERIAL_LEN-1-(gi-OFF)) +: 8];
         end
      end
      // model: characters start at the front, spaces fill the tail
      for (gi = 0; gi < `IDPG_MODEL_CHARS; gi++) begin : g_mod
         if (gi < MODEL_LEN) begin : g_chr
            assign model_ch[gi] = MODEL_STR[8*(MODEL_LEN-1-gi) +: 8];
         end else begin : g_pad
            assign model_ch[gi] = `IDPG_SPACE;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // derived fields
   // ------------------------------------------------------------
   // current capacity product, truncated to the double word
   assign cap_full = cur_geom.cyl * cur_geom.heads * cur_geom.spt;
   assign cap = cap_full[31:0];
   // advanced words are valid when any of their fields is in use
   assign adv_valid = (|modes.adv_pio) | (|modes.dma_supported) | modes.dma_sel_valid;
   // capability word: lba on, dma per input, standby and ready off
   always_comb begin
      caps_word = 16'h0000;
      caps_word[`IDPG_CAP_LBA_BIT] = 1'b1;
      caps_word[`IDPG_CAP_DMA_BIT] = modes.dma_cmds_ok;
      caps_word[`IDPG_CAP_STBY_BIT] = 1'b0;
      caps_word[`IDPG_CAP_RDY_BIT] = 1'b0;
   end
   // pio mode byte clamped to mode 2
   assign pio_byte = ({6'h00, modes.pio_mode} > `IDPG_PIO_MAX) ? `IDPG_PIO_MAX :
                     {6'h00, modes.pio_mode};
   // one-hot selected dma mode, mode 3 code ignored
   always_comb begin
      dma_sel_byte = 8'h00;
      if (modes.dma_sel_valid && modes.dma_selected != 2'h3) begin
         dma_sel_byte[modes.dma_selected] = 1'b1;
      end
   end
   // cycle fields: zero when unsupported, ordering enforced
   assign dma_min_f = (|modes.dma_supported) ? modes.dma_min_ns : 16'h0000;
   assign dma_rec_f = (|modes.dma_supported) ?
                      ((modes.dma_rec_ns < dma_min_f) ? dma_min_f : modes.dma_rec_ns) :
                      16'h0000;
   assign pio_rdy_f = (|modes.adv_pio) ? modes.pio_rdy_ns : 16'h0000;
   assign pio_min_f = (|modes.adv_pio) ?
                      ((modes.pio_min_ns < pio_rdy_f) ? pio_rdy_f : modes.pio_min_ns) :
                      16'h0000;

   // ------------------------------------------------------------
   // word selection
   // ------------------------------------------------------------
   // page contents by word address, everything else zero
   always_comb begin
      next_word = 16'h0000;
      if (addr >= `IDPG_W_SERIAL_LO && addr <= `IDPG_W_SERIAL_HI) begin
         next_word = {serial_ch[2*(addr-`IDPG_W_SERIAL_LO)],
                      serial_ch[2*(addr-`IDPG_W_SERIAL_LO)+1]};
      end else if (addr >= `IDPG_W_FW_LO && addr <= `IDPG_W_FW_HI) begin
         next_word = FW_STR[16*(`IDPG_W_FW_HI-addr) +: 16];
      end else if (addr >= `IDPG_W_MODEL_LO && addr <= `IDPG_W_MODEL_HI) begin
         next_word = {model_ch[2*(addr-`IDPG_W_MODEL_LO)],
                      model_ch[2*(addr-`IDPG_W_MODEL_LO)+1]};
      end else begin
         unique case (addr)
            `IDPG_W_CONFIG: next_word = CONFIG_WORD;
            `IDPG_W_DEF_CYL: next_word = def_geom.cyl;
            `IDPG_W_DEF_HEAD: next_word = {8'h00, def_geom.heads[7:0]};
            `IDPG_W_DEF_SPT: next_word = def_geom.spt;
            `IDPG_W_CARD_MSW: next_word = card_sectors[31:16];
            `IDPG_W_CARD_LSW: next_word = card_sectors[15:0];
            `IDPG_W_ECC: next_word = `IDPG_ECC_COUNT;
            `IDPG_W_MULT_MAX: next_word = {MULT_UPPER, mult_max};
            `IDPG_W_CAPS: next_word = caps_word;
            `IDPG_W_PIO: next_word = {pio_byte, 8'h00};
            `IDPG_W_VALID: next_word = {14'h0000, adv_valid, 1'b1};
            `IDPG_W_CUR_CYL: next_word = cur_geom.cyl;
            `IDPG_W_CUR_HEAD: next_word = cur_geom.heads;
            `IDPG_W_CUR_SPT: next_word = cur_geom.spt;
            `IDPG_W_CAP_LSW: next_word = cap[15:0];
            `IDPG_W_CAP_MSW: next_word = cap[31:16];
            `IDPG_W_MULT_SET: next_word = {7'h00, 1'b1, mult_current};
            `IDPG_W_LBA_LSW: next_word = lba_sectors[15:0];
            `IDPG_W_LBA_MSW: next_word = lba_sectors[31:16];
            `IDPG_W_DMA: next_word = {dma_sel_byte, 5'h00, modes.dma_supported};
            `IDPG_W_ADV_PIO: next_word = {14'h0000, modes.adv_pio};
            `IDPG_W_DMA_MIN: next_word = adv_valid ? dma_min_f : 16'h0000;
            `IDPG_W_DMA_REC: next_word = adv_valid ? dma_rec_f : 16'h0000;
            `IDPG_W_PIO_MIN: next_word = adv_valid ? pio_min_f : 16'h0000;
            `IDPG_W_PIO_RDY: next_word = adv_valid ? pio_rdy_f : 16'h0000;
            `IDPG_W_SECURITY: next_word = {7'h00, sec_max_level, 8'h00};
            default: next_word = 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // transfer sequencing
   // ------------------------------------------------------------
   assign accept = word_valid && word_ready;
   // output slot refills when empty or taken, never past the last word
   assign load = (state == idpg_pkg::IDPG_SEND) && (!word_valid || (accept && !page_last));

   // state: start on identify command, finish after the last word
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= idpg_pkg::IDPG_IDLE;
      end else begin
         unique case (state)
            idpg_pkg::IDPG_IDLE: begin
               if (cmd_valid && cmd_code == `IDPG_CMD_IDENTIFY) begin
                  state <= idpg_pkg::IDPG_SEND;
               end
            end
            idpg_pkg::IDPG_SEND: begin
               if (accept && page_last) begin
                  state <= idpg_pkg::IDPG_DONE;
               end
            end
            idpg_pkg::IDPG_DONE: begin
               state <= idpg_pkg::IDPG_IDLE;
            end
            default: state <= idpg_pkg::IDPG_IDLE;
         endcase
      end
   end

   // fetch address runs one ahead of the word on the port
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         addr <= 8'h00;
      end else if (state == idpg_pkg::IDPG_IDLE) begin
         addr <= 8'h00;
      end else if (load) begin
         addr <= addr + 8'h01;
      end
   end

   // registered data output, loaded from the fetch address
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         word_valid <= 1'b0;
         word_data <= 16'h0000;
         word_addr <= 8'h00;
         page_last <= 1'b0;
      end else if (load) begin
         word_valid <= 1'b1;
         word_data <= next_word;
         word_addr <= addr;
         page_last <= (addr == `IDPG_LAST_WORD);
      end else if (accept) begin
         word_valid <= 1'b0;
         page_last <= 1'b0;
      end
   end

   assign page_busy = (state != idpg_pkg::IDPG_IDLE);
endmodule

// ==== core/idpg_defs.svh ====
// word addresses, field positions and fixed values of the parameter page
`ifndef IDPG_DEFS_SVH
`define IDPG_DEFS_SVH
`define IDPG_W_CONFIG 8'h00
`define IDPG_W_DEF_CYL 8'h01
`define IDPG_W_DEF_HEAD 8'h03
`define IDPG_W_DEF_SPT 8'h06
`define IDPG_W_CARD_MSW 8'h07
`define IDPG_W_CARD_LSW 8'h08
`define IDPG_W_SERIAL_LO 8'h0a
`define IDPG_W_SERIAL_HI 8'h13
`define IDPG_W_ECC 8'h16
`define IDPG_W_FW_LO 8'h17
`define IDPG_W_FW_HI 8'h1a
`define IDPG_W_MODEL_LO 8'h1b
`define IDPG_W_MODEL_HI 8'h2e
`define IDPG_W_MULT_MAX 8'h2f
`define IDPG_W_CAPS 8'h31
`define IDPG_W_PIO 8'h33
`define IDPG_W_VALID 8'h35
`define IDPG_W_CUR_CYL 8'h36
`define IDPG_W_CUR_HEAD 8'h37
`define IDPG_W_CUR_SPT 8'h38
`define IDPG_W_CAP_LSW 8'h39
`define IDPG_W_CAP_MSW 8'h3a
`define IDPG_W_MULT_SET 8'h3b
`define IDPG_W_LBA_LSW 8'h3c
`define IDPG_W_LBA_MSW 8'h3d
`define IDPG_W_DMA 8'h3f
`define IDPG_W_ADV_PIO 8'h40
`define IDPG_W_DMA_MIN 8'h41
`define IDPG_W_DMA_REC 8'h42
`define IDPG_W_PIO_MIN 8'h43
`define IDPG_W_PIO_RDY 8'h44
`define IDPG_W_SECURITY 8'h80
`define IDPG_ECC_COUNT 16'h0004
`define IDPG_SPACE 8'h20
`define IDPG_MULT_REC 8'h80
`define IDPG_CAP_DMA_BIT 8
`define IDPG_CAP_LBA_BIT 9
`define IDPG_CAP_RDY_BIT 11
`define IDPG_CAP_STBY_BIT 13
`define IDPG_PIO_MAX 8'h02
`define IDPG_VALID_CUR_BIT 0
`define IDPG_VALID_ADV_BIT 1
`define IDPG_MSET_VALID_BIT 8
`define IDPG_SEC_LEVEL_BIT 8
`define IDPG_CMD_IDENTIFY 8'hec
`define IDPG_LAST_WORD 8'hff
`define IDPG_SERIAL_CHARS 20
`define IDPG_FW_CHARS 8
`define IDPG_MODEL_CHARS 40
`endif

// ==== core/idpg_pkg.sv ====
// types shared by the parameter page generator
package idpg_pkg;
   // drive geometry, default or current translation
   typedef struct packed {
      logic [15:0] cyl;
      logic [15:0] heads;
      logic [15:0] spt;
   } idpg_geom_t;
   // multiword dma and pio mode settings
   typedef struct packed {
      logic dma_cmds_ok;
      logic [1:0] pio_mode;
      logic [2:0] dma_supported;
      logic dma_sel_valid;
      logic [1:0] dma_selected;
      logic [1:0] adv_pio;
      logic [15:0] dma_min_ns;
      logic [15:0] dma_rec_ns;
      logic [15:0] pio_min_ns;
      logic [15:0] pio_rdy_ns;
   } idpg_modes_t;
   typedef enum logic [1:0] {
      IDPG_IDLE = 2'b00,
      IDPG_SEND = 2'b01,
      IDPG_DONE = 2'b11
   } idpg_state_t;
endpackage

// ==== tb/idpg_page_asserts.sv ====
// concurrent checks on the parameter page ports
`timescale 1ns/10ps
module idpg_page_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic word_ready,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   input wire logic [7:0] word_addr,
   input wire logic page_last,
   input wire logic page_busy
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // command start and word stream
   // ----------------------------------------
   a_cmd_start: assert property (!page_busy && !$past(page_busy) && cmd_valid &&
      cmd_code == 8'hec |=> page_busy ##1 word_valid && word_addr == 8'h00) else $error("no start");
   a_cmd_ignore: assert property (!page_busy && !$past(page_busy) && cmd_valid &&
      cmd_code != 8'hec |=> !page_busy) else $error("foreign command taken");
   a_word_hold: assert property (word_valid && !word_ready |=> word_valid &&
      $stable(word_data) && $stable(word_addr)) else $error("word changed early");
   a_addr_step: assert property (word_valid && word_ready && !page_last |=>
      word_valid && word_addr == $past(word_addr) + 8'h01) else $error("address skipped");
   a_last_flag: assert property (word_valid |-> page_last == (word_addr == 8'hff))
      else $error("last flag wrong");
   a_page_end: assert property (word_valid && word_ready && page_last |=>
      !word_valid ##1 !page_busy) else $error("page did not end");
   a_ecc_word: assert property (word_valid && word_addr == 8'h16 |->
      word_data == 16'h0004) else $error("ecc count wrong");
   a_dma_sel: assert property (word_valid && word_addr == 8'h3f |->
      $onehot0(word_data[15:8]) && word_data[15:11] == 5'h00) else $error("dma select wrong");
endmodule
bind idpg_page idpg_page_chk chk_u (.mclk, .rst_b, .cmd_valid, .cmd_code, .word_ready,
   .word_valid, .word_data, .word_addr, .page_last, .page_busy);

// ==== tb/idpg_host_model.sv ====
// host model that reads the parameter page word by word
`timescale 1ns/10ps
module idpg_host_model (
   input wire logic mclk,
   input wire logic clr,
   input wire logic stall,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   input wire logic [7:0] word_addr,
   output logic word_ready
);
   logic [15:0] pg [256];
   int cnt = 0;
   int addr_err = 0;
   logic [1:0] ph = 2'h0;
   initial word_ready = 1'b0;
   // ready drops one cycle in three while stalling
   always @(negedge mclk) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      word_ready <= !stall || ph != 2'h0;
   end
   // words kept in arrival order, as sector-read data
   always @(posedge mclk) begin
      if (clr) begin
         cnt <= 0;
         addr_err <= 0;
      end else if (word_valid && word_ready) begin
         pg[cnt[7:0]] <= word_data;
         cnt <= cnt + 1;
         if (word_addr !== cnt[7:0]) begin
            addr_err <= addr_err + 1;
         end
      end
   end
endmodule

// ==== tb/tb_top.sv ====
// testbench for the parameter page generator
`timescale 1ns/10ps
`define W(a) host_u.pg[a]
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic clr = 1'b0;
   logic stall = 1'b0;
   idpg_pkg::idpg_geom_t def_geom = '0;
   idpg_pkg::idpg_geom_t cur_geom = '0;
   logic [31:0] card_sectors = 32'h0;
   logic [31:0] lba_sectors = 32'h0;
   logic [7:0] mult_max = 8'h00;
   logic [7:0] mult_current = 8'h00;
   idpg_pkg::idpg_modes_t modes = '0;
   logic sec_max_level = 1'b0;
   logic word_ready, word_valid, page_last, page_busy;
   logic [15:0] word_data;
   logic [7:0] word_addr;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #10 mclk = ~mclk;
   idpg_page #(.SERIAL_STR("SN123456"), .MODEL_STR("CARDMODEL123")) dut_u (.mclk, .rst_b,
      .cmd_valid, .cmd_code, .word_ready, .word_valid, .word_data, .word_addr, .page_last,
      .page_busy, .def_geom, .cur_geom, .card_sectors, .lba_sectors, .mult_max,
      .mult_current, .modes, .sec_max_level);
   idpg_host_model host_u (.mclk, .clr, .stall, .word_valid, .word_data, .word_addr,
      .word_ready);
   // hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_code = c;
      @(negedge mclk);
      cmd_valid = 1'b0;
   endtask
   // request a page and wait until the host holds all of it
   task automatic get_page();
      @(negedge mclk);
      clr = 1'b1;
      @(negedge mclk);
      clr = 1'b0;
      cmd(8'hec);
      for (int n = 0; n < 2000 && (host_u.cnt < 256 || page_busy); n++) @(negedge mclk);
      `CHK(host_u.cnt, 256)
      `CHK(host_u.addr_err, 0)
   endtask
   // full page with host stalls, all mode groups present
   task automatic t_page_a();
      def_geom = '{16'h03c1, 16'h0010, 16'h003f};
      cur_geom = '{16'h1234, 16'h0010, 16'h003f};
      card_sectors = 32'h0047acc0;
      lba_sectors = card_sectors;
      mult_max = 8'h10;
      mult_current = 8'h08;
      modes = '{1'b1, 2'h2, 3'h3, 1'b1, 2'h1, 2'h3, 16'h0078, 16'h0096, 16'h00b4, 16'h0078};
      sec_max_level = 1'b1;
      stall = 1'b1;
      get_page();
      `CHK(`W(7), card_sectors[31:16])
      `CHK(`W(8), card_sectors[15:0])
      `CHK({`W(0), `W(1), `W(3), `W(6)}, 64'h848a_03c1_0010_003f)
      `CHK({`W(2), `W(4), `W(5), `W(9), `W(20), `W(21)}, 96'h0)
      `CHK({`W(48), `W(50), `W(52), `W(62)}, 64'h0)
      `CHK({`W(23), `W(26)}, 32'h3131_3131)
      `CHK({`W(54), `W(55), `W(56)}, 48'h1234_0010_003f)
      `CHK({`W(61), `W(60)}, 32'h0047acc0)
      `CHK({`W(49)[13], `W(49)[11]}, 2'b00)
      `CHK(`W(10), 16'h2020)
      `CHK(`W(16), 16'h534e)
      `CHK(`W(19), 16'h3536)
      `CHK(`W(27), 16'h4341)
      `CHK(`W(32), 16'h3233)
      `CHK(`W(46), 16'h2020)
      `CHK(`W(47), {8'h80, mult_max})
      `CHK(`W(49), 16'h0300)
      `CHK(`W(51), 16'h0200)
      `CHK(`W(53), 16'h0003)
      `CHK({`W(58), `W(57)}, 32'h0047acc0)
      `CHK(`W(59), {8'h01, mult_current})
      `CHK(`W(63), 16'h0203)
      `CHK(`W(64), 16'h0003)
      `CHK(`W(65), 16'h0078)
      `CHK(`W(66), 16'h0096)
      `CHK(`W(68), 16'h0078)
      `CHK(`W(67), 16'h00b4)
      `CHK(`W(128), 16'h0100)
      for (int a = 69; a < 256; a++) if (a != 128) `CHK(`W(a), 16'h0)
      $display("test page_a done");
   endtask
   // foreign codes, no dma, pio mode 3 asked, command while busy
   task automatic t_page_b();
      logic [7:0] bad [3] = '{8'h91, 8'hed, 8'h20};
      for (int i = 0; i < 3; i++) begin
         cmd(bad[i]);
         @(negedge mclk);
         `CHK({page_busy, word_valid}, 2'b00)
      end
      mult_max = 8'h00;
      mult_current = 8'h01;
      modes = '{1'b0, 2'h3, 3'h0, 1'b0, 2'h0, 2'h1, 16'h00f0, 16'h0078, 16'h0078, 16'h00b4};
      sec_max_level = 1'b0;
      stall = 1'b0;
      fork
         get_page();
         begin
            repeat (40) @(negedge mclk);
            cmd(8'hec);
         end
      join
      `CHK(`W(47), 16'h8000)
      `CHK(`W(49), 16'h0200)
      `CHK(`W(51), 16'h0200)
      `CHK(`W(53), 16'h0003)
      `CHK(`W(59), 16'h0101)
      `CHK(`W(63), 16'h0000)
      `CHK({`W(65), `W(66)}, 32'h0)
      `CHK(`W(67), 16'h00b4)
      `CHK({`W(64), `W(68)}, 32'h0001_00b4)
      `CHK(`W(128), 16'h0000)
      $display("test page_b done");
   endtask
   // dma only, recommended cycle below the minimum, top and unused dma selections
   task automatic t_page_c();
      modes = '{1'b1, 2'h0, 3'h4, 1'b1, 2'h2, 2'h0, 16'h0078, 16'h0050, 16'h00b4, 16'h0078};
      get_page();
      `CHK(`W(63), 16'h0404)
      `CHK({`W(65), `W(66)}, 32'h0078_0078)
      `CHK({`W(64), `W(67), `W(68)}, 48'h0)
      `CHK(`W(53), 16'h0003)
      `CHK(`W(51), 16'h0000)
      modes.dma_selected = 2'h3;
      get_page();
      `CHK(`W(63), 16'h0004)
      $display("test page_c done");
   endtask
   initial begin
      repeat (6) @(negedge mclk);
      `CHK({word_valid, page_busy, page_last, word_addr, word_data}, 27'h0)
      rst_b = 1'b1;
      t_page_a();
      t_page_b();
      t_page_c();
      stop_test();
   end
endmodule
